// File: verilog/ppm_port_mux.sv
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module ppm_port_mux #(
    parameter int SYNC_STAGES = 2
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ppm_pkg::ADDR_W-1:0] paddr,
    input wire logic [ppm_pkg::DATA_W-1:0] pwdata,
    output logic [ppm_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire ppm_pkg::ppm_periph_t periph,
    input wire logic [ppm_pkg::PORT_W-1:0] pin_a_in,
    input wire logic [ppm_pkg::PORT_W-1:0] pin_b_in,
    output ppm_pkg::ppm_drive_t drive_a,
    output ppm_pkg::ppm_drive_t drive_b,
    output logic [ppm_pkg::PORT_W-1:0] analog_connect_a,
    output logic [ppm_pkg::PORT_W-1:0] analog_connect_b,
    output logic [ppm_pkg::PORT_W-1:0] slew_limit
);
    import ppm_pkg::*;

    logic [PORT_W-1:0] analog_select_a;
    logic [PORT_W-1:0] analog_select_b;
    logic [PORT_W-1:0] output_latch_a;
    logic [PORT_W-1:0] output_latch_b;
    logic [PORT_W-1:0] direction_a;
    logic [PORT_W-1:0] direction_b;
    logic [PORT_W-1:0] slew_rate_control;
    logic small_package;
    logic [PORT_W-1:0] sync_a [SYNC_STAGES];
    logic [PORT_W-1:0] sync_b [SYNC_STAGES];
    logic [PORT_W-1:0] pin_value_a;
    logic [PORT_W-1:0] pin_value_b;
    ppm_drive_t next_drive_a;
    ppm_drive_t next_drive_b;
    logic [DATA_W-1:0] next_prdata;
    logic next_err;
    logic wr;
    logic rd_setup;

    function automatic logic [DATA_W-1:0] zext(input logic [PORT_W-1:0] v);
        return {{(DATA_W-PORT_W){1'b0}}, v};
    endfunction

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] ofs);
        return a == ofs;
    endfunction

    assign wr = psel && penable && pwrite && pready;
    assign rd_setup = psel && !penable;

    // pin synchronisers
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < SYNC_STAGES; i++) begin
                sync_a[i] <= RST_ZERO;
                sync_b[i] <= RST_ZERO;
            end
        end else begin
            sync_a[0] <= pin_a_in;
            sync_b[0] <= pin_b_in;
            for (int i = 1; i < SYNC_STAGES; i++) begin
                sync_a[i] <= sync_a[i-1];
                sync_b[i] <= sync_b[i-1];
            end
        end
    end

    // digital read path blanked on analog pins
    assign pin_value_a = sync_a[SYNC_STAGES-1] & ~analog_select_a;
    assign pin_value_b = sync_b[SYNC_STAGES-1] & ~analog_select_b;

    // register writes
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            analog_select_a <= RST_ANSEL;
            analog_select_b <= RST_ANSEL_B;
            output_latch_a <= RST_ZERO;
            output_latch_b <= RST_ZERO;
            direction_a <= RST_DIR;
            direction_b <= RST_DIR;
            slew_rate_control <= RST_SLEW;
            small_package <= 1'b0;
        end else if (wr) begin
            if (hit(paddr, OFS_ANSEL_A)) begin
                analog_select_a <= pwdata[PORT_W-1:0] & ANSEL_A_MASK;
            end else if (hit(paddr, OFS_LAT_A) || hit(paddr, OFS_PIN_A)) begin
                output_latch_a <= pwdata[PORT_W-1:0];
            end else if (hit(paddr, OFS_SLEW)) begin
                slew_rate_control <= pwdata[PORT_W-1:0] & SLEW_MASK;
            end else if (hit(paddr, OFS_DIR_A)) begin
                direction_a <= pwdata[PORT_W-1:0];
            end else if (hit(paddr, OFS_DIR_B)) begin
                direction_b <= pwdata[PORT_W-1:0];
            end else if (hit(paddr, OFS_LAT_B) || hit(paddr, OFS_PIN_B)) begin
                output_latch_b <= pwdata[PORT_W-1:0];
            end else if (hit(paddr, OFS_ANSEL_B)) begin
                analog_select_b <= pwdata[PORT_W-1:0];
            end else if (hit(paddr, OFS_PKG)) begin
                small_package <= pwdata[B_PKG_SMALL];
            end
        end
    end

    // read decode
    always_comb begin
        next_prdata = '0;
        next_err = 1'b0;
        if (hit(paddr, OFS_ANSEL_A)) begin
            next_prdata = zext(analog_select_a);
        end else if (hit(paddr, OFS_LAT_A)) begin
            next_prdata = zext(output_latch_a);
        end else if (hit(paddr, OFS_PIN_A)) begin
            next_prdata = zext(pin_value_a);
        end else if (hit(paddr, OFS_SLEW)) begin
            next_prdata = zext(slew_rate_control);
        end else if (hit(paddr, OFS_DIR_A)) begin
            next_prdata = zext(direction_a);
        end else if (hit(paddr, OFS_DIR_B)) begin
            next_prdata = zext(direction_b);
        end else if (hit(paddr, OFS_LAT_B)) begin
            next_prdata = zext(output_latch_b);
        end else if (hit(paddr, OFS_PIN_B)) begin
            next_prdata = zext(pin_value_b);
        end else if (hit(paddr, OFS_ANSEL_B)) begin
            next_prdata = zext(analog_select_b);
        end else if (hit(paddr, OFS_PKG)) begin
            next_prdata = zext({7'h00, small_package} & PKG_MASK);
        end else begin
            next_err = 1'b1;
        end
    end

    // apb: no wait states, pready in the first access cycle, data captured at setup
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pready <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
        end else begin
            pready <= rd_setup;
            if (rd_setup) begin
                prdata <= pwrite ? '0 : next_prdata;
                pslverr <= next_err;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    // port a priority arbitration, digital sources only
    always_comb begin
        next_drive_a.out = output_latch_a;
        next_drive_a.oe = ~direction_a;
        // bit 4: latch q, cmp1, capture 5 (small package only), latch
        if (periph.latch_true_out_en) begin
            next_drive_a.out[B4] = periph.latch_true_out;
            next_drive_a.oe[B4] = 1'b1;
        end else if (periph.comparator1_result_out_en) begin
            next_drive_a.out[B4] = periph.comparator1_result_out;
            next_drive_a.oe[B4] = 1'b1;
        end else if (small_package && periph.capture_compare5_out_en) begin
            next_drive_a.out[B4] = periph.capture_compare5_out;
            next_drive_a.oe[B4] = 1'b1;
        end
        // bit 5: latch nq, cmp2, latch
        if (periph.latch_inverted_out_en) begin
            next_drive_a.out[B5] = periph.latch_inverted_out;
            next_drive_a.oe[B5] = 1'b1;
        end else if (periph.comparator2_result_out_en) begin
            next_drive_a.out[B5] = periph.comparator2_result_out;
            next_drive_a.oe[B5] = 1'b1;
        end
        // bit 6: crystal drive, clock out, latch
        if (periph.crystal_drive_out_en) begin
            next_drive_a.out[B6] = periph.crystal_drive_out;
            next_drive_a.oe[B6] = 1'b1;
        end else if (periph.instruction_clock_out_en) begin
            next_drive_a.out[B6] = periph.instruction_clock_out;
            next_drive_a.oe[B6] = 1'b1;
        end
        // bit 7: oscillator input takes the pin, driver off
        if (periph.crystal_input_en) begin
            next_drive_a.out[B7] = 1'b0;
            next_drive_a.oe[B7] = 1'b0;
        end
    end

    // port b: latch and direction only
    always_comb begin
        next_drive_b.out = output_latch_b;
        next_drive_b.oe = ~direction_b;
    end

    // pin drivers registered; analog mode does not gate them
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            drive_a <= '0;
            drive_b <= '0;
        end else begin
            drive_a <= next_drive_a;
            drive_b <= next_drive_b;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            analog_connect_a <= RST_ZERO;
            analog_connect_b <= RST_ZERO;
            slew_limit <= RST_ZERO;
        end else begin
            analog_connect_a <= analog_select_a;
            analog_connect_b <= analog_select_b;
            slew_limit <= slew_rate_control;
        end
    end

    property p_bit4_top;
        @(posedge clock) disable iff (!resetn)
        periph.latch_true_out_en |=> drive_a.oe[B4]
            && drive_a.out[B4] == $past(periph.latch_true_out);
    endproperty
    a_bit4_top: assert property (p_bit4_top)
        else $error("bit4 not owned by latch q");

    property p_bit4_cmp;
        @(posedge clock) disable iff (!resetn)
        !periph.latch_true_out_en && periph.comparator1_result_out_en
            |=> drive_a.out[B4] == $past(periph.comparator1_result_out);
    endproperty
    a_bit4_cmp: assert property (p_bit4_cmp)
        else $error("bit4 comparator priority wrong");

    property p_bit5;
        @(posedge clock) disable iff (!resetn)
        periph.latch_inverted_out_en
            |=> drive_a.out[B5] == $past(periph.latch_inverted_out);
    endproperty
    a_bit5: assert property (p_bit5)
        else $error("bit5 priority wrong");

    property p_low_latch;
        @(posedge clock) disable iff (!resetn)
        1'b1 |=> drive_a.out[3:0] == $past(output_latch_a[3:0])
            && drive_a.oe[3:0] == ~$past(direction_a[3:0]);
    endproperty
    a_low_latch: assert property (p_low_latch)
        else $error("port a low bits not from latch");

    property p_dir_b;
        @(posedge clock) disable iff (!resetn)
        1'b1 |=> drive_b.oe == ~$past(direction_b)
            && drive_b.out == $past(output_latch_b);
    endproperty
    a_dir_b: assert property (p_dir_b)
        else $error("port b driver mismatch");

    property p_analog;
        @(posedge clock) disable iff (!resetn)
        1'b1 |=> analog_connect_a == $past(analog_select_a);
    endproperty
    a_analog: assert property (p_analog)
        else $error("analog connect mismatch");

    property p_unimpl;
        @(posedge clock) disable iff (!resetn)
        1'b1 |-> (analog_select_a & ~ANSEL_A_MASK) == '0;
    endproperty
    a_unimpl: assert property (p_unimpl)
        else $error("unimplemented bit set");

    property p_ready;
        @(posedge clock) disable iff (!resetn)
        psel && !penable |=> pready ##1 !pready;
    endproperty
    a_ready: assert property (p_ready)
        else $error("apb ready timing wrong");

    property p_bit4_capture;
        @(posedge clock) disable iff (!resetn)
        !periph.latch_true_out_en && !periph.comparator1_result_out_en
            && periph.capture_compare5_out_en && small_package
            |=> drive_a.oe[B4]
            && drive_a.out[B4] == $past(periph.capture_compare5_out);
    endproperty
    a_bit4_capture: assert property (p_bit4_capture)
        else $error("bit4 capture output priority wrong");

    property p_bit5_cmp;
        @(posedge clock) disable iff (!resetn)
        !periph.latch_inverted_out_en && periph.comparator2_result_out_en
            |=> drive_a.oe[B5]
            && drive_a.out[B5] == $past(periph.comparator2_result_out);
    endproperty
    a_bit5_cmp: assert property (p_bit5_cmp)
        else $error("bit5 comparator priority wrong");

    property p_bit6_xtal;
        @(posedge clock) disable iff (!resetn)
        periph.crystal_drive_out_en |=> drive_a.oe[B6]
            && drive_a.out[B6] == $past(periph.crystal_drive_out);
    endproperty
    a_bit6_xtal: assert property (p_bit6_xtal)
        else $error("bit6 crystal drive priority wrong");

    property p_bit6_clk;
        @(posedge clock) disable iff (!resetn)
        !periph.crystal_drive_out_en && periph.instruction_clock_out_en
            |=> drive_a.oe[B6]
            && drive_a.out[B6] == $past(periph.instruction_clock_out);
    endproperty
    a_bit6_clk: assert property (p_bit6_clk)
        else $error("bit6 clock out priority wrong");

    property p_bit7;
        @(posedge clock) disable iff (!resetn)
        periph.crystal_input_en |=> !drive_a.oe[B7];
    endproperty
    a_bit7: assert property (p_bit7)
        else $error("bit7 driver not released for oscillator");

    property p_pin_write;
        @(posedge clock) disable iff (!resetn)
        psel && penable && pwrite && pready && paddr == OFS_PIN_A
            |=> output_latch_a == $past(pwdata[PORT_W-1:0]);
    endproperty
    a_pin_write: assert property (p_pin_write)
        else $error("pin register write missed the latch");

    property p_idle;
        @(posedge clock) disable iff (!resetn)
        !(periph.latch_true_out_en || periph.comparator1_result_out_en
            || periph.capture_compare5_out_en
            || periph.latch_inverted_out_en
            || periph.comparator2_result_out_en
            || periph.crystal_drive_out_en
            || periph.instruction_clock_out_en || periph.crystal_input_en)
            |=> drive_a.out == $past(output_latch_a)
            && drive_a.oe == ~$past(direction_a);
    endproperty
    a_idle: assert property (p_idle)
        else $error("idle port a not following latch");
endmodule

// File: pkg/ppm_pkg.sv
package ppm_pkg;
    localparam int PORT_W = 8;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 12;
    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_ANSEL_A = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_LAT_A = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_PIN_A = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_SLEW = 12'h00C;
    localparam logic [ADDR_W-1:0] OFS_DIR_A = 12'h010;
    localparam logic [ADDR_W-1:0] OFS_DIR_B = 12'h014;
    localparam logic [ADDR_W-1:0] OFS_LAT_B = 12'h018;
    localparam logic [ADDR_W-1:0] OFS_PIN_B = 12'h01C;
    localparam logic [ADDR_W-1:0] OFS_ANSEL_B = 12'h020;
    localparam logic [ADDR_W-1:0] OFS_PKG = 12'h024;
    // implemented-bit masks
    localparam logic [PORT_W-1:0] ANSEL_A_MASK = 8'h2F;
    localparam logic [PORT_W-1:0] SLEW_MASK = 8'h1F;
    localparam logic [PORT_W-1:0] PKG_MASK = 8'h01;
    // reset values
    localparam logic [PORT_W-1:0] RST_ANSEL = 8'h2F;
    localparam logic [PORT_W-1:0] RST_ANSEL_B = 8'h3F;
    localparam logic [PORT_W-1:0] RST_DIR = 8'hFF;
    localparam logic [PORT_W-1:0] RST_ZERO = 8'h00;
    localparam logic [PORT_W-1:0] RST_SLEW = 8'h1F;
    // bit positions on port a and in the package register
    localparam int B4 = 4;
    localparam int B5 = 5;
    localparam int B6 = 6;
    localparam int B7 = 7;
    localparam int B_PKG_SMALL = 0;

    typedef struct packed {
        logic latch_true_out_en;
        logic latch_true_out;
        logic comparator1_result_out_en;
        logic comparator1_result_out;
        logic capture_compare5_out_en;
        logic capture_compare5_out;
        logic latch_inverted_out_en;
        logic latch_inverted_out;
        logic comparator2_result_out_en;
        logic comparator2_result_out;
        logic crystal_drive_out_en;
        logic crystal_drive_out;
        logic instruction_clock_out_en;
        logic instruction_clock_out;
        logic crystal_input_en;
    } ppm_periph_t;

    typedef struct packed {
        logic [PORT_W-1:0] out;
        logic [PORT_W-1:0] oe;
    } ppm_drive_t;
endpackage

// File: testbench/ppm_pin_model.sv
`timescale 1ns/1ps
// pads: driven pins loop back, undriven port a pins wander
module ppm_pin_model (
    input wire logic clock,
    input wire ppm_pkg::ppm_drive_t drive_a,
    input wire ppm_pkg::ppm_drive_t drive_b,
    input wire logic [ppm_pkg::PORT_W-1:0] ext_b,
    output logic [ppm_pkg::PORT_W-1:0] pin_a_in,
    output logic [ppm_pkg::PORT_W-1:0] pin_b_in
);
    import ppm_pkg::*;
    logic [PORT_W-1:0] float_pat = 8'h55;
    always @(posedge clock) begin
        float_pat <= ~float_pat;
    end
    assign pin_a_in = (drive_a.oe & drive_a.out) | (~drive_a.oe & float_pat);
    assign pin_b_in = (drive_b.oe & drive_b.out) | (~drive_b.oe & ext_b);
endmodule

// File: testbench/port_pin_output_priority_mux_tb.sv
`timescale 1ns/1ps
module port_pin_output_priority_mux_tb;
    import ppm_pkg::*;
    logic clock, resetn, psel, penable, pwrite, pready, pslverr;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata;
    ppm_periph_t periph;
    ppm_drive_t drive_a, drive_b;
    logic [PORT_W-1:0] pin_a_in, pin_b_in, ext_b, ac_a, ac_b, slew;
    logic [32:0] q[$];
    logic [32:0] e;
    logic [31:0] r;
    logic [7:0] lat, m, xa;
    int failures = 0;
    int checked = 0;
    int seed = 32'h7e6d;
    ppm_port_mux u_dut (.clock(clock), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .periph(periph),
        .pin_a_in(pin_a_in), .pin_b_in(pin_b_in), .drive_a(drive_a),
        .drive_b(drive_b), .analog_connect_a(ac_a), .analog_connect_b(ac_b),
        .slew_limit(slew));
    ppm_pin_model u_pins (.clock(clock), .drive_a(drive_a),
        .drive_b(drive_b), .ext_b(ext_b), .pin_a_in(pin_a_in),
        .pin_b_in(pin_b_in));
    task close_out;
        if (failures == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task chk(input logic [32:0] got, input logic [32:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [ADDR_W-1:0] a,
             input logic [31:0] d, input logic [32:0] x);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        if (!w) q.push_back(x);
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        @(posedge clock);
        while (pready !== 1'b1) begin
            n++;
            if (n > 20) begin
                failures++;
                close_out();
            end
            @(posedge clock);
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask
    task rd(input logic [ADDR_W-1:0] a, input logic [7:0] x);
        apb(1'b0, a, 32'h0, {1'b0, 24'h0, x});
    endtask
    task settle;
        repeat (2) @(posedge clock);
        @(negedge clock);
    endtask
    function automatic logic [7:0] exp_a(ppm_periph_t p, logic [7:0] l,
                                         logic sm);
        logic [7:0] x;
        x = l;
        if (p.latch_true_out_en) x[4] = p.latch_true_out;
        else if (p.comparator1_result_out_en) x[4] = p.comparator1_result_out;
        else if (sm && p.capture_compare5_out_en) x[4] = p.capture_compare5_out;
        if (p.latch_inverted_out_en) x[5] = p.latch_inverted_out;
        else if (p.comparator2_result_out_en) x[5] = p.comparator2_result_out;
        if (p.crystal_drive_out_en) x[6] = p.crystal_drive_out;
        else if (p.instruction_clock_out_en) x[6] = p.instruction_clock_out;
        return x;
    endfunction
    always @(posedge clock) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1
            && pwrite === 1'b0) begin
            if (q.size() == 0) begin
                chk({pslverr, prdata}, 33'h1FFFFFFFF);
            end else begin
                e = q.pop_front();
                chk({pslverr, prdata}, e);
            end
        end
    end
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    initial begin
        resetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        periph = '0;
        ext_b = 8'h5A;
        repeat (20) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        @(negedge clock);
        chk(drive_a.oe, 0);
        chk(ac_a, 8'h2F);
        chk(ac_b, 8'h3F);
        rd(OFS_ANSEL_A, 8'h2F);
        rd(OFS_DIR_A, 8'hFF);
        rd(OFS_LAT_A, 8'h00);
        wr(OFS_ANSEL_A, 32'hFFFFFFFF);
        rd(OFS_ANSEL_A, 8'h2F);
        wr(OFS_SLEW, 32'h000000FF);
        rd(OFS_SLEW, 8'h1F);
        chk(slew, 8'h1F);
        apb(1'b0, 12'hFFC, 32'h0, {1'b1, 32'h0});
        wr(OFS_LAT_B, 32'hA5);
        rd(OFS_LAT_B, 8'hA5);
        rd(OFS_PIN_B, 8'h40);
        wr(OFS_ANSEL_B, 32'h0);
        rd(OFS_PIN_B, 8'h5A);
        wr(OFS_PIN_B, 32'h3C);
        rd(OFS_LAT_B, 8'h3C);
        chk(drive_b.oe, 0);
        wr(OFS_DIR_B, 32'h0);
        settle();
        chk({drive_b.oe, drive_b.out}, 16'hFF3C);
        rd(OFS_PIN_B, 8'h3C);
        wr(OFS_DIR_A, 32'h0);
        for (int pk = 0; pk < 2; pk++) begin
            wr(OFS_PKG, pk);
            for (int i = 0; i < 24; i++) begin
                r = $random(seed);
                lat = r[7:0];
                wr(OFS_LAT_A, {24'h0, lat});
                periph <= (i == 0) ? '0 : r[22:8];
                settle();
                m = periph.crystal_input_en ? 8'h7F : 8'hFF;
                xa = exp_a(periph, lat, pk[0]) & m;
                chk(drive_a.out & m, xa);
                chk(drive_a.oe, m);
            end
        end
        wr(OFS_PIN_A, 32'h96);
        periph <= '0;
        settle();
        rd(OFS_LAT_A, 8'h96);
        rd(OFS_PIN_A, 8'h90);
        resetn <= 1'b0;
        repeat (3) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        @(negedge clock);
        chk(drive_a.oe, 0);
        chk(ac_a, 8'h2F);
        rd(OFS_DIR_A, 8'hFF);
        rd(OFS_LAT_A, 8'h00);
        close_out();
    end
endmodule
